// ==== uart_rx_defs.vh ====
// Purpose: constants for the serial receiver with holding fifo and loop modes
// Assumes: 8-bit register port with a 2-bit address
// Notes: definitions only
`ifndef UART_RX_DEFS_VH
`define UART_RX_DEFS_VH
// register addresses
`define ADR_MODE 2'h0
`define ADR_STAT 2'h1
`define ADR_RXBUF 2'h2
`define ADR_LOOP 2'h3
// mode_reg_one fields
`define MD_PAR_EN 2
`define MD_PAR_ODD 3
`define MD_ERR_BLK 4
`define MD_RX_RTS 5
`define MD_REQ_FULL 6
`define MODE_RST 8'h03
// command_reg fields
`define CMD_RX_EN 0
`define CMD_RX_DIS 1
`define CMD_RX_RST 2
`define CMD_ERR_RST 3
// loop modes
`define LOOP_NORMAL 2'h0
`define LOOP_ECHO 2'h1
`define LOOP_LOCAL 2'h2
`define LOOP_REMOTE 2'h3
// 16x tick counts
`define HALF_LAST 4'h7
`define BIT_LAST 4'hF
`endif

// ==== uart_rx_loop.v ====
// Purpose: receive half of an async serial channel with holding fifo and loop modes
// Assumes: 16x tick enables come from an outside baud divider on ref_clk_i
// Notes: registers on a plain strobe port; read data one cycle after the strobe
//
// Function
// - start bit checked low over eight ticks
// - sample bit centres, lsb first, then stop
// - clear unused upper bits of short characters
// - character available set at stop midpoint
// - hunt next start; low framing error restarts
// - error flags updated at character boundary
// - full-low character stores zero with break
// - mid-character break stores damaged char first
// - three holding entries plus shift register
// - each entry keeps parity, framing, break bits
// - buffer read returns oldest entry, then pops
// - full flag; request source selects full/available
// - error mode: head status or block OR
// - status reads never pop the fifo
// - full fifo: char waits, next start overruns
// - flow mode negates rts on a start while full
// - disabled still readable; reset clears receiver
// - loop mode selection takes effect at once outside echo modes
// - echo modes leave only when idle or at the stop sample
// - automatic echo resends bits, blocks cpu
// - local loopback feeds transmitter into receiver
// - remote loopback echoes, status all inactive
`include "uart_rx_defs.vh"
`default_nettype none
module uart_rx_loop #(
  parameter DEPTH = 3
) (
  // clock and reset
  input wire ref_clk_i,
  input wire rst_n_i,
  // register port
  input wire [1:0] addr_i,
  input wire [7:0] wr_data_i,
  input wire wr_stb_i,
  input wire rd_stb_i,
  output wire [7:0] rd_data_o,
  // 16x bit clock enables
  input wire rx_tick16_i,
  input wire tx_tick16_i,
  // serial line
  input wire rxd_i,
  output wire txd_o,
  output wire rts_n_o,
  // transmitter side
  input wire tx_serial_i,
  input wire tx_ready_i,
  input wire tx_empty_i,
  output wire tx_cpu_block_o,
  // receive service request
  output wire rx_req_o
);

  localparam EW = 11;
  localparam CW = $clog2(DEPTH + 1);
  localparam [4:0] S_IDLE = 5'h01;
  localparam [4:0] S_START = 5'h02;
  localparam [4:0] S_DATA = 5'h04;
  localparam [4:0] S_STOP = 5'h08;
  localparam [4:0] S_BRK = 5'h10;

  // three-stage input synchroniser with agreement filter
  reg rx_s1_ff, rx_s2_ff, rx_s3_ff, rx_filt_ff;
  always @(posedge ref_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      rx_s1_ff <= 1'b1;
      rx_s2_ff <= 1'b1;
      rx_s3_ff <= 1'b1;
      rx_filt_ff <= 1'b1;
    end else begin
      rx_s1_ff <= rxd_i;
      rx_s2_ff <= rx_s1_ff;
      rx_s3_ff <= rx_s2_ff;
      if (rx_s2_ff == rx_s3_ff) begin
        rx_filt_ff <= rx_s3_ff;
      end
    end
  end

  // control registers
  reg [7:0] mode_ff;
  reg [1:0] loop_req_ff, loop_ff;
  reg rx_en_ff;
  wire wr_cmd = wr_stb_i && (addr_i == `ADR_STAT);
  wire cmd_rst = wr_cmd && wr_data_i[`CMD_RX_RST];
  wire cmd_err_rst = wr_cmd && wr_data_i[`CMD_ERR_RST];
  wire is_echo = (loop_ff == `LOOP_ECHO);
  wire is_local = (loop_ff == `LOOP_LOCAL);
  wire is_remote = (loop_ff == `LOOP_REMOTE);
  wire tick = is_local ? tx_tick16_i : rx_tick16_i;
  wire rx_in = is_local ? tx_serial_i : rx_filt_ff;
  wire rx_run = rx_en_ff || is_local || is_remote;

  always @(posedge ref_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      mode_ff <= `MODE_RST;
      rx_en_ff <= 1'b0;
    end else begin
      if (wr_stb_i && (addr_i == `ADR_MODE)) begin
        mode_ff <= wr_data_i;
      end
      if (cmd_rst) begin
        rx_en_ff <= 1'b0;
      end else if (wr_cmd && wr_data_i[`CMD_RX_EN]) begin
        rx_en_ff <= 1'b1;
      end else if (wr_cmd && wr_data_i[`CMD_RX_DIS]) begin
        rx_en_ff <= 1'b0;
      end
    end
  end

  // character geometry
  wire [3:0] nlen = {2'b00, mode_ff[1:0]} + 4'h5;
  wire [3:0] nbits = nlen + {3'b000, mode_ff[`MD_PAR_EN]};

  // receive state machine
  reg [4:0] state_ff;
  reg [3:0] cnt_ff, bit_ff;
  reg [8:0] sh_ff;
  reg prev_ff;
  wire [3:0] shamt = 4'h9 - nbits;
  wire [8:0] aligned = sh_ff >> shamt;
  wire [7:0] dmask = 8'hFF >> (4'h8 - nlen);
  wire [7:0] cdata = aligned[7:0] & dmask;
  wire pbit = aligned[nlen];
  wire brk = (aligned == 9'h000) && !rx_in;
  wire fe = !rx_in;
  // parity is checked in echo mode but not in remote loopback
  wire pe = mode_ff[`MD_PAR_EN] && !is_remote &&
            ((^cdata) ^ pbit ^ mode_ff[`MD_PAR_ODD]);
  wire live = rx_run && !cmd_rst && tick;
  wire start_ok = live && (state_ff == S_START) && !rx_in && (cnt_ff == `HALF_LAST);
  wire stop_evt = live && (state_ff == S_STOP) && (cnt_ff == `BIT_LAST);

  always @(posedge ref_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      state_ff <= S_IDLE;
      cnt_ff <= 4'h0;
      bit_ff <= 4'h0;
      sh_ff <= 9'h000;
      prev_ff <= 1'b1;
    end else if (cmd_rst || !rx_run) begin
      state_ff <= S_IDLE;
      cnt_ff <= 4'h0;
      prev_ff <= 1'b1;
    end else if (tick) begin
      prev_ff <= rx_in;
      case (state_ff)
        S_IDLE: begin
          if (prev_ff && !rx_in) begin
            state_ff <= S_START;
            cnt_ff <= 4'h0;
          end
        end
        S_START: begin
          if (rx_in) begin
            state_ff <= S_IDLE;
          end else if (cnt_ff == `HALF_LAST) begin
            state_ff <= S_DATA;
            cnt_ff <= 4'h0;
            bit_ff <= 4'h0;
            sh_ff <= 9'h000;
          end else begin
            cnt_ff <= cnt_ff + 4'h1;
          end
        end
        S_DATA: begin
          if (cnt_ff == `BIT_LAST) begin
            sh_ff <= {rx_in, sh_ff[8:1]};
            cnt_ff <= 4'h0;
            if (bit_ff == nbits - 4'h1) begin
              state_ff <= S_STOP;
            end else begin
              bit_ff <= bit_ff + 4'h1;
            end
          end else begin
            cnt_ff <= cnt_ff + 4'h1;
          end
        end
        S_STOP: begin
          if (cnt_ff == `BIT_LAST) begin
            cnt_ff <= 4'h0;
            if (brk) begin
              state_ff <= S_BRK;
            end else if (fe && (cdata != 8'h00)) begin
              // low line after a damaged char is checked as a new start
              state_ff <= S_START;
            end else begin
              state_ff <= S_IDLE;
            end
          end else begin
            cnt_ff <= cnt_ff + 4'h1;
          end
        end
        S_BRK: begin
          if (!rx_in) begin
            cnt_ff <= 4'h0;
          end else if (cnt_ff == `HALF_LAST) begin
            state_ff <= S_IDLE;
          end else begin
            cnt_ff <= cnt_ff + 4'h1;
          end
        end
        default: begin
          state_ff <= S_IDLE;
        end
      endcase
    end
  end

  // holding fifo, head at entry 0
  reg [DEPTH*EW-1:0] mem_ff;
  reg [CW-1:0] count_ff;
  reg pend_ff, ovr_ff;
  reg [EW-1:0] pend_data_ff;
  wire [EW-1:0] new_ent = {brk, fe, pe, cdata};
  wire [EW-1:0] head = mem_ff[EW-1:0];
  wire fifo_full = (count_ff == DEPTH[CW-1:0]);
  // only a receive buffer read pops; status reads leave the fifo alone
  wire pop = rd_stb_i && (addr_i == `ADR_RXBUF) && (count_ff != {CW{1'b0}}) &&
             !is_remote && !cmd_rst;
  wire room = !fifo_full || pop;
  wire take = stop_evt && !is_remote;
  wire push = !cmd_rst && room && (pend_ff || take);
  wire [EW-1:0] push_ent = pend_ff ? pend_data_ff : new_ent;
  wire [CW-1:0] wr_idx = pop ? count_ff - {{(CW-1){1'b0}}, 1'b1} : count_ff;
  wire [(DEPTH+1)*EW-1:0] mem_ext = {{EW{1'b0}}, mem_ff};
  wire [DEPTH*EW-1:0] nxt_mem;
  wire [CW-1:0] nxt_count = count_ff + {{(CW-1){1'b0}}, push} -
                            {{(CW-1){1'b0}}, pop};

  genvar gi;
  generate
    for (gi = 0; gi < DEPTH; gi = gi + 1) begin : g_ent
      assign nxt_mem[gi*EW +: EW] = (push && (wr_idx == gi)) ? push_ent :
                                    pop ? mem_ext[(gi+1)*EW +: EW] :
                                    mem_ff[gi*EW +: EW];
    end
  endgenerate

  always @(posedge ref_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      mem_ff <= {DEPTH*EW{1'b0}};
      count_ff <= {CW{1'b0}};
      pend_ff <= 1'b0;
      pend_data_ff <= {EW{1'b0}};
      ovr_ff <= 1'b0;
    end else if (cmd_rst) begin
      mem_ff <= {DEPTH*EW{1'b0}};
      count_ff <= {CW{1'b0}};
      pend_ff <= 1'b0;
      ovr_ff <= 1'b0;
    end else begin
      mem_ff <= nxt_mem;
      count_ff <= nxt_count;
      if (take && !room) begin
        pend_ff <= 1'b1;
        pend_data_ff <= new_ent;
      end else if (start_ok && pend_ff) begin
        pend_ff <= 1'b0;
      end else if (pend_ff && room) begin
        pend_ff <= 1'b0;
      end
      // an overrun in the same cycle as an error reset is kept
      if (start_ok && pend_ff) begin
        ovr_ff <= 1'b1;
      end else if (cmd_err_rst) begin
        ovr_ff <= 1'b0;
      end
    end
  end

  // block mode accumulation of every entry reaching the head
  reg fresh_ff;
  reg [2:0] acc_ff;
  wire fresh = (pop && ((count_ff > {{(CW-1){1'b0}}, 1'b1}) || push)) ||
               (push && (count_ff == {CW{1'b0}}));
  always @(posedge ref_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      fresh_ff <= 1'b0;
      acc_ff <= 3'h0;
    end else if (cmd_rst) begin
      fresh_ff <= 1'b0;
      acc_ff <= 3'h0;
    end else begin
      fresh_ff <= fresh;
      if (fresh_ff) begin
        acc_ff <= (cmd_err_rst ? 3'h0 : acc_ff) | head[10:8];
      end else if (cmd_err_rst) begin
        acc_ff <= 3'h0;
      end
    end
  end

  // status assembly; error bits only mean something with a char waiting
  wire avail = (count_ff != {CW{1'b0}}) && !is_remote;
  wire tx_hide = is_echo || is_remote;
  wire [2:0] err3 = !avail ? 3'h0 :
                    mode_ff[`MD_ERR_BLK] ? acc_ff : head[10:8];
  wire [7:0] status = {err3, ovr_ff && !is_remote, tx_empty_i && !tx_hide,
                       tx_ready_i && !tx_hide, fifo_full && !is_remote, avail};

  // loop mode control
  reg tail_ff;
  reg [3:0] tail_cnt_ff;
  wire echo_any = is_echo || is_remote;
  wire leave_ok = stop_evt || (state_ff == S_IDLE);
  always @(posedge ref_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      loop_req_ff <= `LOOP_NORMAL;
      loop_ff <= `LOOP_NORMAL;
      tail_ff <= 1'b0;
      tail_cnt_ff <= 4'h0;
    end else begin
      if (wr_stb_i && (addr_i == `ADR_LOOP)) begin
        loop_req_ff <= wr_data_i[1:0];
      end
      if (loop_ff != loop_req_ff) begin
        if (!echo_any) begin
          loop_ff <= loop_req_ff;
        end else if (leave_ok) begin
          loop_ff <= loop_req_ff;
          tail_ff <= is_echo && stop_evt;
          tail_cnt_ff <= 4'h0;
        end
      end
      // keep echoing the second half of the stop bit after leaving automatic echo for normal mode
      if (tail_ff && rx_tick16_i) begin
        if (tail_cnt_ff == `HALF_LAST) begin
          tail_ff <= 1'b0;
        end else begin
          tail_cnt_ff <= tail_cnt_ff + 4'h1;
        end
      end
    end
  end

  // registered outputs
  reg [7:0] rd_data_ff;
  reg txd_ff, rts_n_ff, block_ff, req_ff;
  reg [7:0] nxt_rd_data;
  always @* begin
    nxt_rd_data = 8'h00;
    if (rd_stb_i) begin
      case (addr_i)
        `ADR_MODE: nxt_rd_data = mode_ff;
        `ADR_STAT: nxt_rd_data = status;
        `ADR_RXBUF: nxt_rd_data = is_remote ? 8'h00 : head[7:0];
        default: nxt_rd_data = {6'h00, loop_req_ff};
      endcase
    end
  end

  always @(posedge ref_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      rd_data_ff <= 8'h00;
      txd_ff <= 1'b1;
      rts_n_ff <= 1'b0;
      block_ff <= 1'b0;
      req_ff <= 1'b0;
    end else begin
      rd_data_ff <= nxt_rd_data;
      case (loop_ff)
        `LOOP_ECHO: txd_ff <= rx_filt_ff;
        `LOOP_REMOTE: txd_ff <= rx_filt_ff;
        `LOOP_LOCAL: txd_ff <= 1'b1;
        default: txd_ff <= tail_ff ? rx_filt_ff : tx_serial_i;
      endcase
      block_ff <= echo_any || tail_ff;
      // rts negates on a start while the fifo is full, reasserts when it has room; outside flow mode it stays asserted
      if (cmd_rst || !mode_ff[`MD_RX_RTS]) begin
        rts_n_ff <= 1'b0;
      end else if (start_ok && fifo_full) begin
        rts_n_ff <= 1'b1;
      end else if (!fifo_full) begin
        rts_n_ff <= 1'b0;
      end
      if (cmd_rst) begin
        req_ff <= 1'b0;
      end else begin
        req_ff <= mode_ff[`MD_REQ_FULL] ? (fifo_full && !is_remote) : avail;
      end
    end
  end

  assign rd_data_o = rd_data_ff;
  assign txd_o = txd_ff;
  assign rts_n_o = rts_n_ff;
  assign tx_cpu_block_o = block_ff;
  assign rx_req_o = req_ff;

endmodule
`default_nettype wire

// ==== uart_rx_loop_checker.sv ====
// Purpose: protocol checks on the receiver's register port and serial outputs
// Assumes: single clock domain; register writes are tracked from the port itself
// Notes: the design's loop mode lags the tracked copies, so loop mode checks wait two cycles after a write;
// loop checks skip a switch out of an echo mode, which may wait for a stop bit
`include "uart_rx_defs.vh"
`default_nettype none
module uart_rx_loop_checker #(
  parameter DEPTH = 3
) (
  // clock and reset
  input wire logic ref_clk_i,
  input wire logic rst_n_i,
  // register port
  input wire logic [1:0] addr_i,
  input wire logic [7:0] wr_data_i,
  input wire logic wr_stb_i,
  input wire logic rd_stb_i,
  input wire logic [7:0] rd_data_o,
  // serial and service outputs
  input wire logic txd_o,
  input wire logic rts_n_o,
  input wire logic tx_cpu_block_o,
  input wire logic rx_req_o
);
  logic [1:0] loop_ff, loop_q_ff, loop_qq_ff, prev_loop_ff;
  logic [7:0] mode_ff;
  logic rd_stat_ff, rd_buf_ff, rd_any_ff, rts_free_ff;
  always @(posedge ref_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      loop_ff <= `LOOP_NORMAL;
      loop_q_ff <= `LOOP_NORMAL;
      loop_qq_ff <= `LOOP_NORMAL;
      prev_loop_ff <= `LOOP_NORMAL;
      mode_ff <= `MODE_RST;
      rts_free_ff <= 1'b1;
      rd_stat_ff <= 1'b0;
      rd_buf_ff <= 1'b0;
      rd_any_ff <= 1'b0;
    end else begin
      if (wr_stb_i && addr_i == `ADR_LOOP) begin
        loop_ff <= wr_data_i[1:0];
        prev_loop_ff <= loop_ff;
      end
      if (wr_stb_i && addr_i == `ADR_MODE) mode_ff <= wr_data_i;
      loop_q_ff <= loop_ff;
      loop_qq_ff <= loop_q_ff;
      rts_free_ff <= !mode_ff[`MD_RX_RTS];
      rd_stat_ff <= rd_stb_i && addr_i == `ADR_STAT;
      rd_buf_ff <= rd_stb_i && addr_i == `ADR_RXBUF;
      rd_any_ff <= rd_stb_i;
    end
  end
  default clocking cb @(posedge ref_clk_i);
  endclocking
  default disable iff (!rst_n_i);
  property p_rd_idle;
    !rd_any_ff |-> rd_data_o == 8'h00;
  endproperty
  a_rd_idle: assert property (p_rd_idle) else $error("read data not zero outside read");
  property p_full_avail;
    rd_stat_ff && rd_data_o[1] |-> rd_data_o[0];
  endproperty
  a_full_avail: assert property (p_full_avail) else $error("full without available");
  property p_err_quiet;
    rd_stat_ff && !rd_data_o[0] |-> rd_data_o[7:5] == 3'h0;
  endproperty
  a_err_quiet: assert property (p_err_quiet) else $error("error flags with empty fifo");
  property p_rx_reset;
    wr_stb_i && addr_i == `ADR_STAT && wr_data_i[`CMD_RX_RST] && !loop_ff[1]
      |-> ##2 !rx_req_o && !rts_n_o;
  endproperty
  a_rx_reset: assert property (p_rx_reset) else $error("receiver reset left outputs");
  property p_echo_block;
    loop_ff == `LOOP_ECHO && loop_q_ff == `LOOP_ECHO |-> ##1 tx_cpu_block_o;
  endproperty
  a_echo_block: assert property (p_echo_block) else $error("echo not blocking cpu");
  property p_echo_stat;
    rd_stat_ff && loop_q_ff == `LOOP_ECHO && loop_qq_ff == `LOOP_ECHO
      |-> rd_data_o[3:2] == 2'h0;
  endproperty
  a_echo_stat: assert property (p_echo_stat) else $error("tx flags active in echo");
  property p_remote_buf;
    rd_buf_ff && loop_q_ff == `LOOP_REMOTE && loop_qq_ff == `LOOP_REMOTE && !prev_loop_ff[0]
      |-> rd_data_o == 8'h00;
  endproperty
  a_remote_buf: assert property (p_remote_buf) else $error("data read in remote loop");
  property p_local_mark;
    loop_ff == `LOOP_LOCAL && loop_q_ff == `LOOP_LOCAL && !prev_loop_ff[0] |-> ##1 txd_o;
  endproperty
  a_local_mark: assert property (p_local_mark) else $error("output not marking in local");
  property p_rts_idle;
    !mode_ff[`MD_RX_RTS] && rts_free_ff |-> !rts_n_o;
  endproperty
  a_rts_idle: assert property (p_rts_idle) else $error("rts negated outside flow mode");
endmodule
bind uart_rx_loop uart_rx_loop_checker #(.DEPTH(DEPTH)) u_uart_rx_loop_checker (
  .ref_clk_i(ref_clk_i), .rst_n_i(rst_n_i), .addr_i(addr_i), .wr_data_i(wr_data_i),
  .wr_stb_i(wr_stb_i), .rd_stb_i(rd_stb_i), .rd_data_o(rd_data_o), .txd_o(txd_o),
  .rts_n_o(rts_n_o), .tx_cpu_block_o(tx_cpu_block_o), .rx_req_o(rx_req_o));
`default_nettype wire

// ==== uart_line_model.sv ====
// Purpose: remote serial sender driving the receive line, plus the 16x tick
// Assumes: one bit lasts 16 ticks; a tick every TICK_DIV clocks
// Notes: line idles at mark; a low stop bit leaves the line low for the caller
`default_nettype none
module uart_line_model #(
  parameter int TICK_DIV = 4
) (
  // clock
  input wire logic ref_clk_i,
  // tick and line
  output logic tick_o,
  output logic line_o
);
  timeunit 1ns;
  timeprecision 1ns;
  int div_cnt = 0;
  initial begin
    tick_o = 1'b0;
    line_o = 1'b1;
  end
  always @(posedge ref_clk_i) begin
    div_cnt <= (div_cnt == TICK_DIV - 1) ? 0 : div_cnt + 1;
    tick_o <= (div_cnt == TICK_DIV - 1);
  end
  task automatic hold(input logic b, input int ticks);
    line_o <= b;
    repeat (ticks) @(posedge ref_clk_i iff tick_o);
  endtask
  // lsb first, optional parity, one stop bit
  task automatic send_char(input logic [7:0] d, input int n, input logic pe,
      input logic par, input logic stop);
    hold(1'b0, 16);
    for (int i = 0; i < n; i++) hold(d[i], 16);
    if (pe) hold(par, 16);
    hold(stop, 16);
  endtask
endmodule
`default_nettype wire

// ==== uart_rx_loop_tb.sv ====
// Purpose: register-level tests of the serial receiver and loop modes
// Assumes: transmitter flags tied high; a second line model plays the transmitter's bit
// Notes: status and buffer reads come in either order
`include "uart_rx_defs.vh"
`default_nettype none
module uart_rx_loop_tb;
  timeunit 1ns;
  timeprecision 1ns;
  localparam logic [7:0] ST = 8'h0C;
  logic ref_clk_i = 1'b0;
  logic rst_n_i = 1'b0;
  logic [1:0] addr_i = 2'h0;
  logic [7:0] wr_data_i = 8'h00;
  logic wr_stb_i = 1'b0;
  logic rd_stb_i = 1'b0;
  logic [7:0] rd_data_o, rd_val;
  logic tick, rxd, tx_line, txd_o, rts_n_o, tx_cpu_block_o, rx_req_o;
  int error_cnt = 0;
  int samples_checked = 0;
  uart_line_model u_uart_line_model (.ref_clk_i(ref_clk_i), .tick_o(tick), .line_o(rxd));
  // same divider phase as the receive model, so its ticks match
  uart_line_model u_uart_line_model_tx (.ref_clk_i(ref_clk_i), .tick_o(), .line_o(tx_line));
  uart_rx_loop u_uart_rx_loop (
    .ref_clk_i(ref_clk_i), .rst_n_i(rst_n_i), .addr_i(addr_i), .wr_data_i(wr_data_i),
    .wr_stb_i(wr_stb_i), .rd_stb_i(rd_stb_i), .rd_data_o(rd_data_o), .rx_tick16_i(tick),
    .tx_tick16_i(tick), .rxd_i(rxd), .txd_o(txd_o), .rts_n_o(rts_n_o), .tx_serial_i(tx_line),
    .tx_ready_i(1'b1), .tx_empty_i(1'b1), .tx_cpu_block_o(tx_cpu_block_o),
    .rx_req_o(rx_req_o));
  initial begin
    forever #25 ref_clk_i = ~ref_clk_i;
  end
  task automatic wr(input logic [1:0] a, input logic [7:0] d);
    @(posedge ref_clk_i);
    addr_i <= a;
    wr_data_i <= d;
    wr_stb_i <= 1'b1;
    @(posedge ref_clk_i);
    wr_stb_i <= 1'b0;
  endtask
  task automatic chk(input string what, input logic [7:0] exp, input logic [7:0] got);
    samples_checked++;
    if (got !== exp) begin
      error_cnt++;
      $display("wrong value %s expected %h seen %h", what, exp, got);
    end
  endtask
  task automatic rdchk(input logic [1:0] a, input logic [7:0] exp, input string what);
    @(posedge ref_clk_i);
    addr_i <= a;
    rd_stb_i <= 1'b1;
    @(posedge ref_clk_i);
    rd_stb_i <= 1'b0;
    #1 rd_val = rd_data_o;
    chk(what, exp, rd_val);
  endtask
  task automatic tx8(input logic [7:0] d);
    u_uart_line_model.send_char(d, 8, 1'b0, 1'b0, 1'b1);
  endtask
  task automatic done(input string name);
    $display("test %s finished", name);
  endtask
  task automatic summarize();
    $display("checks %0d mismatches %0d", samples_checked, error_cnt);
    if (error_cnt == 0 && samples_checked > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask
  // a run needs about 16500 cycles
  initial begin
    repeat (60000) @(posedge ref_clk_i);
    error_cnt++;
    summarize();
  end
  initial begin
    repeat (20) @(posedge ref_clk_i);
    rst_n_i <= 1'b1;
    rdchk(`ADR_MODE, `MODE_RST, "mode");
    rdchk(`ADR_STAT, ST, "status");
    wr(`ADR_STAT, 8'h01);
    u_uart_line_model.hold(1'b0, 4);
    u_uart_line_model.hold(1'b1, 16);
    tx8(8'hA5);
    rdchk(`ADR_STAT, ST | 8'h01, "status");
    rdchk(`ADR_STAT, ST | 8'h01, "status");
    chk("rx_req", 8'h01, {7'h0, rx_req_o});
    rdchk(`ADR_RXBUF, 8'hA5, "rxbuf");
    rdchk(`ADR_STAT, ST, "status");
    done("basic");
    for (int n = 5; n <= 8; n++) begin
      wr(`ADR_MODE, 8'(n - 5));
      u_uart_line_model.send_char(8'hD6, n, 1'b0, 1'b0, 1'b1);
      rdchk(`ADR_RXBUF, 8'hD6 & 8'((1 << n) - 1), "rxbuf");
    end
    for (int k = 0; k < 4; k++) begin
      wr(`ADR_MODE, 8'h07 | (k[1] ? 8'h08 : 8'h00));
      u_uart_line_model.send_char(8'h31, 8, 1'b1, 1'b1 ^ k[1] ^ k[0], 1'b1);
      rdchk(`ADR_STAT, ST | 8'h01 | (k[0] ? 8'h20 : 8'h00), "status");
      rdchk(`ADR_RXBUF, 8'h31, "rxbuf");
    end
    done("length and parity");
    wr(`ADR_MODE, `MODE_RST);
    u_uart_line_model.send_char(8'h0F, 8, 1'b0, 1'b0, 1'b0);
    u_uart_line_model.hold(1'b0, 16 * 11);
    u_uart_line_model.hold(1'b1, 16);
    rdchk(`ADR_STAT, ST | 8'h41, "status");
    rdchk(`ADR_RXBUF, 8'h0F, "rxbuf");
    rdchk(`ADR_STAT, ST | 8'hC1, "status");
    rdchk(`ADR_RXBUF, 8'h00, "rxbuf");
    done("break");
    wr(`ADR_MODE, 8'h63);
    for (int i = 1; i <= 5; i++) tx8(8'(i));
    chk("rx_req", 8'h01, {7'h0, rx_req_o});
    chk("rts_n", 8'h01, {7'h0, rts_n_o});
    rdchk(`ADR_STAT, ST | 8'h13, "status");
    for (int i = 1; i <= 4; i++) rdchk(`ADR_RXBUF, 8'(i == 4 ? 5 : i), "rxbuf");
    chk("rts_n", 8'h00, {7'h0, rts_n_o});
    rdchk(`ADR_STAT, ST | 8'h10, "status");
    wr(`ADR_STAT, 8'h08);
    rdchk(`ADR_STAT, ST, "status");
    done("overrun");
    wr(`ADR_MODE, 8'h17);
    u_uart_line_model.send_char(8'h31, 8, 1'b1, 1'b0, 1'b1);
    u_uart_line_model.send_char(8'h31, 8, 1'b1, 1'b1, 1'b1);
    rdchk(`ADR_RXBUF, 8'h31, "rxbuf");
    rdchk(`ADR_STAT, ST | 8'h21, "status");
    wr(`ADR_STAT, 8'h08);
    rdchk(`ADR_STAT, ST | 8'h01, "status");
    rdchk(`ADR_RXBUF, 8'h31, "rxbuf");
    done("block mode");
    wr(`ADR_MODE, `MODE_RST);
    tx8(8'h66);
    wr(`ADR_STAT, 8'h02);
    tx8(8'h77);
    rdchk(`ADR_RXBUF, 8'h66, "rxbuf");
    rdchk(`ADR_STAT, ST, "status");
    wr(`ADR_STAT, 8'h01);
    tx8(8'h55);
    wr(`ADR_STAT, 8'h04);
    tx8(8'h44);
    rdchk(`ADR_STAT, ST, "status");
    wr(`ADR_STAT, 8'h01);
    done("disable and reset");
    wr(`ADR_LOOP, {6'h00, `LOOP_ECHO});
    // a short low pulse is echoed but rejected as a start
    u_uart_line_model.hold(1'b0, 8);
    chk("txd", 8'h00, {7'h0, txd_o});
    u_uart_line_model.hold(1'b1, 16);
    tx8(8'h3C);
    chk("cpu_block", 8'h01, {7'h0, tx_cpu_block_o});
    rdchk(`ADR_STAT, 8'h01, "status");
    wr(`ADR_LOOP, {6'h00, `LOOP_NORMAL});
    wr(`ADR_LOOP, {6'h00, `LOOP_REMOTE});
    tx8(8'hC3);
    // the queued echo char must stay hidden and unpopped
    rdchk(`ADR_RXBUF, 8'h00, "rxbuf");
    rdchk(`ADR_STAT, 8'h00, "status");
    wr(`ADR_LOOP, {6'h00, `LOOP_NORMAL});
    wr(`ADR_LOOP, {6'h00, `LOOP_LOCAL});
    // the outside line goes low and must be ignored
    u_uart_line_model.hold(1'b0, 1);
    u_uart_line_model_tx.send_char(8'h5A, 8, 1'b0, 1'b0, 1'b1);
    chk("txd", 8'h01, {7'h0, txd_o});
    u_uart_line_model.hold(1'b1, 16);
    wr(`ADR_LOOP, {6'h00, `LOOP_NORMAL});
    rdchk(`ADR_RXBUF, 8'h3C, "rxbuf");
    rdchk(`ADR_RXBUF, 8'h5A, "rxbuf");
    rdchk(`ADR_STAT, ST, "status");
    done("loops");
    summarize();
  end
endmodule
`default_nettype wire
